// ==== core/vic_top.sv ====
// Vectored interrupt controller top with primary enable register and CPU handshake
// Contract
// - Reset vectors 0x0000; source i vectors 0x0003 plus 8*i; 8,17 reserved.
// - Global gate bit 7 low blocks every request regardless of masks.
// - With gate high, a source requests only when its mask bit is set.
// - Mask bit 6 gates SPI at 0x0033, from any of four SPI flags.
// - Mask bit 5 gates timer 2 at 0x002B, from either overflow flag.
// - Mask bit 4 gates UART0 at 0x0023, from receive or transmit done.
// - Mask bit 3 gates timer 1 at 0x001B from control bit 7.
// - Mask bit 2 gates external pin 1 at 0x0013 from control bit 3.
// - Mask bit 1 gates timer 0 at 0x000B from control bit 5.
// - Mask bit 0 gates external pin 0 at 0x0003 from control bit 1.
// - Timer 5 at 0x00A3, index 20, gated by extended enable bit 20 (ext_enable_i[20]).
// - Primary enable register at 0xA8, read/write, bit-addressable, resets zero.
// - Equal-level simultaneous requests resolve to lowest fixed index.
// - Pending flags set regardless of enables; enables only gate requests.
// - High preempts running low service; high service is never preempted.
// - Requests sampled and priority decoded on every system clock cycle with clk_en_i high in VIC_IDLE; a pending offer holds until ack_i.
`timescale 1ns/1ps
`include "vic_cfg.svh"
module vic_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire vic_pkg::vic_sfr_req_s sfr_i,
  output logic [7:0] sfr_rdata_o,
  output logic [7:0] iep_o,
  input wire logic [7:0] timer_external_control_reg_i,
  input wire logic timer2_high_overflow_i,
  input wire logic timer2_low_overflow_i,
  input wire logic uart0_receive_done_i,
  input wire logic uart0_transmit_done_i,
  input wire logic spi_transfer_done_i,
  input wire logic spi_write_collision_i,
  input wire logic spi_mode_fault_i,
  input wire logic spi_receive_overrun_i,
  input wire logic timer5_high_overflow_i,
  input wire logic timer5_low_overflow_i,
  input wire vic_pkg::vic_src_t ext_pending_i,
  input wire vic_pkg::vic_src_t ext_enable_i,
  input wire vic_pkg::vic_src_t priority_i,
  input wire logic reti_i,
  input wire logic ack_i,
  output vic_pkg::vic_req_s irq_o
);
  import vic_pkg::*;

  // ******************************
  // Primary enable register
  // ******************************
  logic [7:0] iep_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      iep_q <= `VIC_IEP_RESET;
    end else if (clk_en_i && sfr_i.addr == `VIC_IEP_ADDR) begin
      if (sfr_i.wr) begin
        iep_q <= sfr_i.wdata;
      end else if (sfr_i.bit_wr) begin
        iep_q[sfr_i.bit_sel] <= sfr_i.bit_val;
      end
    end
  end
  assign iep_o = iep_q;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      if (sfr_i.addr == `VIC_IEP_ADDR) begin
        sfr_rdata_o <= iep_q;
      end else begin
        sfr_rdata_o <= 8'h00;
      end
    end
  end

  // ******************************
  // Source gathering and gating
  // ******************************
  // Flags come from peripherals on this clock, so no synchroniser is needed
  vic_src_t pend;
  vic_src_t en;
  vic_src_t elig;
  always_comb begin
    pend = ext_pending_i;
    en = ext_enable_i;
    pend[0] = timer_external_control_reg_i[`VIC_TCR_P0_BIT];
    pend[1] = timer_external_control_reg_i[`VIC_TCR_T0_BIT];
    pend[2] = timer_external_control_reg_i[`VIC_TCR_P1_BIT];
    pend[3] = timer_external_control_reg_i[`VIC_TCR_T1_BIT];
    pend[4] = uart0_receive_done_i | uart0_transmit_done_i;
    pend[5] = timer2_high_overflow_i | timer2_low_overflow_i;
    pend[6] = spi_transfer_done_i | spi_write_collision_i
              | spi_mode_fault_i | spi_receive_overrun_i;
    pend[`VIC_T5_INDEX] = timer5_high_overflow_i | timer5_low_overflow_i;
    en[6:0] = iep_q[6:0];
    en[`VIC_RSVD_A] = 1'b0;
    en[`VIC_RSVD_B] = 1'b0;
    // Gate overrides every mask
    elig = iep_q[`VIC_GATE_BIT] ? (pend & en) : '0;
  end

  // ******************************
  // Service level tracking
  // ******************************
  // Nesting depth: low_act_q low routine active, high_act_q high routine active
  logic low_act_q;
  logic high_act_q;
  vic_state_e state_q;
  logic grant_high_q;

  logic take_ack;
  assign take_ack = clk_en_i && state_q == VIC_OFFER && ack_i;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_act_q <= 1'b0;
      high_act_q <= 1'b0;
    end else if (clk_en_i) begin
      if (take_ack && grant_high_q) begin
        high_act_q <= 1'b1;
      end else if (take_ack) begin
        low_act_q <= 1'b1;
      end else if (reti_i && high_act_q) begin
        high_act_q <= 1'b0;
      end else if (reti_i) begin
        low_act_q <= 1'b0;
      end
    end
  end

  // ******************************
  // Arbitration
  // ******************************
  logic hi_found;
  logic lo_found;
  vic_idx_t hi_idx;
  vic_idx_t lo_idx;

  vic_arbiter #(.NSRC(`VIC_NUM_SRC)) u_arb_high (
    .req_i(elig & priority_i),
    .found_o(hi_found),
    .idx_o(hi_idx)
  );

  vic_arbiter #(.NSRC(`VIC_NUM_SRC)) u_arb_low (
    .req_i(elig & ~priority_i),
    .found_o(lo_found),
    .idx_o(lo_idx)
  );

  logic win_valid;
  logic win_high;
  vic_idx_t win_idx;
  always_comb begin
    win_valid = 1'b0;
    win_high = 1'b0;
    win_idx = hi_idx;
    if (high_act_q) begin
      win_valid = 1'b0;
    end else if (hi_found) begin
      win_valid = 1'b1;
      win_high = 1'b1;
    end else if (lo_found && !low_act_q) begin
      win_valid = 1'b1;
      win_idx = lo_idx;
    end
  end

  function automatic vic_vec_t vec_of(input vic_idx_t idx);
    vec_of = `VIC_VEC_BASE + vic_vec_t'({11'h000, idx} << `VIC_VEC_STEP_SHIFT);
  endfunction : vec_of

  // ******************************
  // CPU request handshake
  // ******************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= VIC_IDLE;
      irq_o <= '{valid: 1'b0, vector: `VIC_RESET_VECTOR, high: 1'b0};
      grant_high_q <= 1'b0;
    end else if (clk_en_i) begin
      case (state_q)
        VIC_IDLE: begin
          if (win_valid) begin
            state_q <= VIC_OFFER;
            irq_o <= '{valid: 1'b1, vector: vec_of(win_idx), high: win_high};
            grant_high_q <= win_high;
          end
        end
        VIC_OFFER: begin
          if (ack_i) begin
            state_q <= VIC_IDLE;
            irq_o.valid <= 1'b0;
          end
        end
        default: begin
          state_q <= VIC_IDLE;
        end
      endcase
    end
  end
endmodule : vic_top

// ==== core/vic_cfg.svh ====
// Constants for the vectored interrupt controller
`ifndef VIC_CFG_SVH
`define VIC_CFG_SVH
// ******************************
// Register map
// ******************************
`define VIC_IEP_ADDR 8'ha8
`define VIC_IEP_RESET 8'h00
`define VIC_GATE_BIT 7
// ******************************
// Vector layout
// ******************************
`define VIC_RESET_VECTOR 16'h0000
`define VIC_VEC_BASE 16'h0003
`define VIC_VEC_STEP_SHIFT 3
`define VIC_NUM_SRC 21
`define VIC_RSVD_A 8
`define VIC_RSVD_B 17
`define VIC_T5_INDEX 20
`define VIC_T5_EXT_BIT 5
// ******************************
// Flag positions in the timer/external control register
// ******************************
`define VIC_TCR_T1_BIT 7
`define VIC_TCR_T0_BIT 5
`define VIC_TCR_P1_BIT 3
`define VIC_TCR_P0_BIT 1
`endif

// ==== core/vic_pkg.sv ====
// Types shared by the vectored interrupt controller
package vic_pkg;
  typedef logic [20:0] vic_src_t;
  typedef logic [4:0] vic_idx_t;
  typedef logic [15:0] vic_vec_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic bit_wr;
    logic [2:0] bit_sel;
    logic bit_val;
  } vic_sfr_req_s;
  typedef struct packed {
    logic valid;
    vic_vec_t vector;
    logic high;
  } vic_req_s;
  typedef enum logic [1:0] {
    VIC_IDLE,
    VIC_OFFER
  } vic_state_e;
endpackage : vic_pkg

// ==== core/vic_arbiter.sv ====
// Fixed-order priority pick among eligible sources
`timescale 1ns/1ps
module vic_arbiter #(
  parameter int NSRC = 21
) (
  input wire logic [NSRC-1:0] req_i,
  output logic found_o,
  output logic [4:0] idx_o
);
  always_comb begin
    found_o = 1'b0;
    idx_o = 5'h0;
    // Walk downward so the lowest index wins
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        found_o = 1'b1;
        idx_o = 5'(i);
      end
    end
  end
endmodule : vic_arbiter

// ==== tb/vic_sva.sv ====
// Port assertions for the vectored interrupt controller
`timescale 1ns/1ps
module vic_sva (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire vic_pkg::vic_sfr_req_s sfr_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic [7:0] iep_o,
  input wire logic ack_i,
  input wire vic_pkg::vic_req_s irq_o
);
  import vic_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  wire a8 = sfr_i.addr == 8'ha8;
  // Gate must be low on both sides of the edge, since a write may open it
  property p_gate; !iep_o[7] && !irq_o.valid ##1 !iep_o[7] |-> !irq_o.valid; endproperty
  a_gate: assert property (p_gate) else $error("request with gate off");
  property p_hold; irq_o.valid && !ack_i |=> irq_o.valid && $stable(irq_o.vector); endproperty
  a_hold: assert property (p_hold) else $error("offer dropped early");
  property p_ack; clk_en_i && irq_o.valid && ack_i |=> !irq_o.valid; endproperty
  a_ack: assert property (p_ack) else $error("offer kept after ack");
  property p_vec; irq_o.valid |-> irq_o.vector[2:0] == 3'h3 && irq_o.vector <= 16'h00a3
    && !(irq_o.vector inside {16'h0043, 16'h008b}); endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_wr; clk_en_i && a8 && sfr_i.wr |=> iep_o == $past(sfr_i.wdata); endproperty
  a_wr: assert property (p_wr) else $error("byte write lost");
  property p_bit; clk_en_i && a8 && sfr_i.bit_wr && !sfr_i.wr
    |=> iep_o[$past(sfr_i.bit_sel)] == $past(sfr_i.bit_val); endproperty
  a_bit: assert property (p_bit) else $error("bit write lost");
  property p_rd; clk_en_i && a8 |=> sfr_rdata_o == $past(iep_o); endproperty
  a_rd: assert property (p_rd) else $error("bad read data");
  property p_rd0; clk_en_i && !a8 |=> sfr_rdata_o == 8'h00; endproperty
  a_rd0: assert property (p_rd0) else $error("other address read");
  // A low enable must freeze the register, the read data and the offer alike
  property p_frz; !clk_en_i |=> $stable(iep_o) && $stable(sfr_rdata_o) && $stable(irq_o); endproperty
  a_frz: assert property (p_frz) else $error("state moved while frozen");
  c_ack: cover property (irq_o.valid && ack_i);
  c_high: cover property (irq_o.valid && irq_o.high);
  c_bit: cover property (a8 && sfr_i.bit_wr);
endmodule : vic_sva
bind vic_top vic_sva vic_sva_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .sfr_i(sfr_i),
  .sfr_rdata_o(sfr_rdata_o),
  .iep_o(iep_o), .ack_i(ack_i), .irq_o(irq_o));

// ==== tb/vic_cpu_model.sv ====
// CPU side model: takes offered vectored calls after a chosen lag
`timescale 1ns/1ps
module vic_cpu_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire vic_pkg::vic_req_s irq_i,
  input wire logic [1:0] lag_i,
  output logic ack_o
);
  import vic_pkg::*;
  logic [1:0] wait_q;
  // Ack only against an offered request, one cycle long, so a slow CPU is also exercised
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_q <= 2'h0;
      ack_o <= 1'b0;
    end else begin
      ack_o <= irq_i.valid && !ack_o && wait_q == lag_i;
      wait_q <= (irq_i.valid && !ack_o && wait_q != lag_i) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule : vic_cpu_model

// ==== tb/vic_tb_top.sv ====
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
module vic_tb_top;
  import vic_pkg::*;
  localparam vic_sfr_req_s IDLE = '{8'ha8, 8'h00, 1'b0, 1'b0, 3'h0, 1'b0};
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ack;
  logic reti = 1'b0;
  logic clk_en = 1'b1;
  vic_src_t ext_pend = '0;
  logic [13:0] fl = '0;
  logic [1:0] lag = '0;
  vic_src_t ext_en = '0;
  vic_src_t prio = '0;
  vic_sfr_req_s sfr = IDLE;
  logic [7:0] rdata, iep;
  vic_req_s irq;
  int mismatches = 0;
  int n_checks = 0;
  always #10 clk_i = ~clk_i;
  vic_top vic_top_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en), .sfr_i(sfr), .sfr_rdata_o(rdata),
    .iep_o(iep), .timer_external_control_reg_i({fl[3], 1'b0, fl[1], 1'b0, fl[2], 1'b0, fl[0], 1'b0}),
    .timer2_high_overflow_i(fl[6]), .timer2_low_overflow_i(fl[7]), .uart0_receive_done_i(fl[4]),
    .uart0_transmit_done_i(fl[5]), .spi_transfer_done_i(fl[8]), .spi_write_collision_i(fl[9]),
    .spi_mode_fault_i(fl[10]), .spi_receive_overrun_i(fl[11]), .timer5_high_overflow_i(fl[12]),
    .timer5_low_overflow_i(fl[13]), .ext_pending_i(ext_pend), .ext_enable_i(ext_en), .priority_i(prio),
    .reti_i(reti), .ack_i(ack), .irq_o(irq));
  vic_cpu_model vic_cpu_model_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .irq_i(irq), .lag_i(lag), .ack_o(ack));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic bus(input vic_sfr_req_s r);
    @(posedge clk_i);
    sfr <= r;
    @(posedge clk_i);
    sfr <= IDLE;
  endtask : bus
  task automatic rd(input logic [7:0] exp);
    @(posedge clk_i);
    @(negedge clk_i);
    chk("read", {8'h00, exp}, {8'h00, rdata});
  endtask : rd
  task automatic quiet;
    repeat (8) begin
      @(negedge clk_i);
      chk("valid", 16'h0000, {15'h0000, irq.valid});
    end
  endtask : quiet
  task automatic take(input logic [15:0] exp);
    int n;
    n = 0;
    while (!(irq.valid === 1'b1 && ack === 1'b1)) begin
      @(negedge clk_i);
      n++;
      if (n > 60) begin
        mismatches++;
        end_sim;
      end
    end
    chk("vector", exp, irq.vector);
  endtask : take
  task automatic ret;
    @(posedge clk_i);
    reti <= 1'b1;
    @(posedge clk_i);
    reti <= 1'b0;
  endtask : ret
  task automatic t_gate;
    @(posedge clk_i);
    fl <= 14'h3fff;
    bus('{8'ha8, 8'h7f, 1'b1, 1'b0, 3'h0, 1'b0});
    quiet;
    bus('{8'ha8, 8'h80, 1'b1, 1'b0, 3'h0, 1'b0});
    rd(8'h80);
    quiet;
    bus('{8'hb8, 8'hff, 1'b1, 1'b0, 3'h0, 1'b0});
    rd(8'h80);
    @(posedge clk_i);
    fl <= 14'h3000;
    for (int b = 0; b < 7; b++) bus('{8'ha8, 8'h00, 1'b0, 1'b1, b[2:0], 1'b1});
    rd(8'hff);
    quiet;
  endtask : t_gate
  task automatic t_flags;
    // Timer 5 flags are still up from the gate scenario; drop them on the same edge that opens its enable
    @(posedge clk_i);
    fl <= '0;
    ext_en <= '1;
    for (int k = 0; k < 14; k++) begin
      @(posedge clk_i);
      fl <= 14'h0001 << k;
      lag <= k[1:0];
      take(16'h0003 + 16'((k < 4 ? k : k < 6 ? 4 : k < 8 ? 5 : k < 12 ? 6 : 20) * 8));
      @(posedge clk_i);
      fl <= '0;
      ret;
    end
  endtask : t_flags
  task automatic t_prio;
    @(posedge clk_i);
    fl <= 14'h3fff;
    take(16'h0003);
    chk("high", 16'h0000, {15'h0000, irq.high});
    quiet;
    @(posedge clk_i);
    prio[5] <= 1'b1;
    take(16'h002b);
    chk("high", 16'h0001, {15'h0000, irq.high});
    @(posedge clk_i);
    prio <= '1;
    quiet;
    @(posedge clk_i);
    fl <= '0;
    ret;
    ret;
  endtask : t_prio
  task automatic t_ext;
    @(posedge clk_i);
    ext_pend <= 21'h020100;
    quiet;
    @(posedge clk_i);
    ext_pend <= 21'h0c0080;
    take(16'h003b);
    @(posedge clk_i);
    ext_pend <= '0;
    ret;
  endtask : t_ext
  task automatic t_freeze;
    @(posedge clk_i);
    clk_en <= 1'b0;
    fl <= 14'h0004;
    bus('{8'ha8, 8'h00, 1'b1, 1'b0, 3'h0, 1'b0});
    quiet;
    chk("enable", 16'h00ff, {8'h00, iep});
    @(posedge clk_i);
    clk_en <= 1'b1;
    take(16'h0013);
    @(posedge clk_i);
    fl <= '0;
    ret;
  endtask : t_freeze
  task automatic t_reset;
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    @(negedge clk_i);
    chk("enable", 16'h0000, {8'h00, iep});
    chk("read", 16'h0000, {8'h00, rdata});
    chk("vector", 16'h0000, irq.vector);
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(8'h00);
  endtask : t_reset
  initial begin
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(negedge clk_i);
    chk("enable", 16'h0000, {8'h00, iep});
    t_gate;
    t_flags;
    t_prio;
    t_ext;
    t_freeze;
    t_reset;
    end_sim;
  end
endmodule : vic_tb_top
